/* File: common/wtc_pkg.sv */
// Constants, register map and types shared by the watchdog timer core.
package wtc_pkg;

   // ----------------------------------------------------------------
   // Clock rates and dividers
   // ----------------------------------------------------------------
   localparam int CLK_FREQ_KHZ = 10000;
   localparam int RC_FREQ_KHZ = 31;
   localparam int RC_DIV = CLK_FREQ_KHZ / RC_FREQ_KHZ;
   localparam int RC_W = 9;
   localparam logic [RC_W-1:0] RC_LAST = RC_W'(RC_DIV - 1);
   localparam int PRE_RATIO_SHORT = 32;
   localparam int PRE_RATIO_LONG = 128;
   localparam int PRE_W = 7;
   localparam logic [PRE_W-1:0] PRE_LAST_SHORT = PRE_W'(PRE_RATIO_SHORT - 1);
   localparam logic [PRE_W-1:0] PRE_LAST_LONG = PRE_W'(PRE_RATIO_LONG - 1);
   localparam int BASE_PERIOD_SHORT_MS = 1;
   localparam int BASE_PERIOD_LONG_MS = 4;
   localparam int POST_W = 15;
   localparam int POST_SEL_W = 4;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFF_CONFIG = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h08;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam int BIT_FIXED_EN = 7;
   localparam int BIT_WIN_OFF = 6;
   localparam int BIT_CFG_UNIMP = 5;
   localparam int BIT_PRE_SEL = 4;
   localparam int LSB_POST_SEL = 0;
   localparam int BIT_SOFT_EN = 5;
   localparam int BIT_TIMEOUT = 4;
   localparam int BIT_SLEEP = 3;
   localparam int BIT_IDLE = 2;

   localparam logic RST_FIXED_EN = 1'h1;
   localparam logic RST_WIN_OFF = 1'h1;
   localparam logic RST_PRE_SEL = 1'h1;
   localparam logic [POST_SEL_W-1:0] RST_POST_SEL = 4'hF;
   localparam logic RST_SOFT_EN = 1'h0;
   localparam logic RST_FLAG = 1'h0;

   // ----------------------------------------------------------------
   // Power states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PWR_RUN,
      PWR_SLEEP,
      PWR_IDLE
   } wtc_pwr_t;

endpackage : wtc_pkg

/* File: common/wtc_div_if.sv */
// Signals between the watchdog core and one of its divider stages.
`timescale 1ns/1ns
interface wtc_div_if #(parameter int W = 8) ();
   logic clr;
   logic inc;
   logic [W-1:0] last;
   logic [W-1:0] cnt;
   logic tick;
   modport div (input clr, input inc, input last, output cnt, output tick);
   modport ctl (output clr, output inc, output last, input cnt, input tick);
endinterface : wtc_div_if

/* File: verilog/wtc_divider.sv */
// One divider stage: counts advance pulses and ticks on the last count.
`timescale 1ns/1ns
module wtc_divider #(
   parameter int W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   wtc_div_if.div d
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   wire at_last = (cnt_q == d.last);

   assign d.tick = d.inc && at_last;
   assign d.cnt = cnt_q;
   assign cnt_d = (d.clr || d.tick) ? '0 : (d.inc ? cnt_q + W'(1) : cnt_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule : wtc_divider

/* File: verilog/wtc_core.sv */
// Watchdog timer core with an AXI4-Lite register slave.
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/1ns
module wtc_core (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [wtc_pkg::ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [wtc_pkg::ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic dog_clear_instr,
   input wire logic power_save_instr,
   input wire logic power_save_idle,
   input wire logic clock_switch_done,
   input wire logic wake_other,
   output logic low_power_rc_osc_en,
   output logic dog_reset_req,
   output logic dog_wake
);
   import wtc_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic aw_free_q;
   logic w_free_q;
   logic [ADDR_W-1:0] wr_addr_q;
   logic [31:0] wr_data_q;
   logic wr_strb0_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic dog_fixed_enable_q;
   logic window_mode_off_q;
   logic prescale_ratio_sel_q;
   logic [POST_SEL_W-1:0] postscale_sel_q;
   logic dog_soft_enable_q;
   logic dog_timeout_flag_q;
   logic sleep_flag_q;
   logic idle_flag_q;
   logic dog_timeout_flag_d;
   logic sleep_flag_d;
   logic idle_flag_d;
   wtc_pwr_t pwr_q;
   wtc_pwr_t pwr_d;
   logic osc_en_q;
   logic reset_req_q;
   logic wake_q;

   wtc_div_if #(.W(RC_W)) osc_div ();
   wtc_div_if #(.W(PRE_W)) pre_div ();
   wtc_div_if #(.W(POST_W)) post_div ();

   // ---------------------------------------------------------------
   // Counter chain
   // ---------------------------------------------------------------
   wire running = (pwr_q == PWR_RUN);
   wire dog_en = dog_fixed_enable_q || dog_soft_enable_q;
   wire windowed = !window_mode_off_q && dog_fixed_enable_q;
   wire [POST_W-1:0] post_last = POST_W'((16'h0001 << postscale_sel_q) - 16'h0001);
   wire [POST_W-1:0] win_start = post_last - (post_last >> 2);
   wire win_early = windowed && (post_div.cnt < win_start);
   wire post_timeout = post_div.tick;
   wire enter_save = running && power_save_instr;
   wire run_clear = running && dog_clear_instr && dog_en;
   wire win_violation = run_clear && win_early;
   wire dog_event = post_timeout || win_violation;
   wire leave_save = !running && (wake_other || post_timeout);
   wire clr_all = clock_switch_done || enter_save || leave_save || run_clear ||
                  !dog_en || dog_event;

   assign osc_div.inc = dog_en;
   assign osc_div.last = RC_LAST;
   assign osc_div.clr = clr_all;
   assign pre_div.inc = osc_div.tick;
   assign pre_div.last = prescale_ratio_sel_q ? PRE_LAST_LONG : PRE_LAST_SHORT;
   assign pre_div.clr = clr_all;
   assign post_div.inc = pre_div.tick;
   assign post_div.last = post_last;
   assign post_div.clr = clr_all;

   wtc_divider #(.W(RC_W)) u_osc (.aclk(aclk), .aresetn(aresetn), .d(osc_div));
   wtc_divider #(.W(PRE_W)) u_pre (.aclk(aclk), .aresetn(aresetn), .d(pre_div));
   wtc_divider #(.W(POST_W)) u_post (.aclk(aclk), .aresetn(aresetn), .d(post_div));

   // ---------------------------------------------------------------
   // Power state
   // ---------------------------------------------------------------
   always_comb begin
      pwr_d = pwr_q;
      case (pwr_q)
         PWR_RUN: begin
            if (power_save_instr) begin
               pwr_d = power_save_idle ? PWR_IDLE : PWR_SLEEP;
            end
         end
         PWR_SLEEP, PWR_IDLE: begin
            if (leave_save) begin
               pwr_d = PWR_RUN;
            end
         end
         default: begin
            pwr_d = PWR_RUN;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Register decode
   // ---------------------------------------------------------------
   wire wr_go = !aw_free_q && !w_free_q && !bvalid_q;
   wire wr_cfg = wr_addr_q == OFF_CONFIG;
   wire wr_ctl = wr_addr_q == OFF_CONTROL;
   wire wr_hit = wr_cfg || wr_ctl || (wr_addr_q == OFF_COUNT);
   wire cfg_we = wr_go && wr_cfg && wr_strb0_q;
   wire ctl_we = wr_go && wr_ctl && wr_strb0_q;
   wire rd_take = arvalid && arready_q;
   wire rd_cfg = araddr == OFF_CONFIG;
   wire rd_ctl = araddr == OFF_CONTROL;
   wire rd_cnt = araddr == OFF_COUNT;
   wire rd_hit = rd_cfg || rd_ctl || rd_cnt;
   wire [31:0] cfg_word = {24'h000000, dog_fixed_enable_q, window_mode_off_q, 1'h1,
                           prescale_ratio_sel_q, postscale_sel_q};
   wire [31:0] ctl_word = {26'h0000000, dog_soft_enable_q, dog_timeout_flag_q,
                           sleep_flag_q, idle_flag_q, 2'h0};
   wire [31:0] cnt_word = {17'h00000, post_div.cnt};
   wire [31:0] rd_word = rd_cfg ? cfg_word : (rd_ctl ? ctl_word : (rd_cnt ? cnt_word : 32'h0));

   assign dog_timeout_flag_d = dog_event ||
                               (dog_timeout_flag_q && !(ctl_we && !wr_data_q[BIT_TIMEOUT]));
   assign sleep_flag_d = (enter_save && !power_save_idle) ||
                         (sleep_flag_q && !(ctl_we && !wr_data_q[BIT_SLEEP]));
   assign idle_flag_d = (enter_save && power_save_idle) ||
                        (idle_flag_q && !(ctl_we && !wr_data_q[BIT_IDLE]));

   // ---------------------------------------------------------------
   // AXI4-Lite channels
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_free_q <= 1'h1;
         w_free_q <= 1'h1;
         wr_addr_q <= '0;
         wr_data_q <= 32'h0;
         wr_strb0_q <= 1'h0;
         bvalid_q <= 1'h0;
         bresp_q <= RESP_OKAY;
      end else begin
         if (awvalid && aw_free_q) begin
            aw_free_q <= 1'h0;
            wr_addr_q <= {awaddr[ADDR_W-1:2], 2'h0};
         end
         if (wvalid && w_free_q) begin
            w_free_q <= 1'h0;
            wr_data_q <= wdata;
            wr_strb0_q <= wstrb[0];
         end
         if (wr_go) begin
            bvalid_q <= 1'h1;
            bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && bready) begin
            bvalid_q <= 1'h0;
            aw_free_q <= 1'h1;
            w_free_q <= 1'h1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'h1;
         rvalid_q <= 1'h0;
         rdata_q <= 32'h0;
         rresp_q <= RESP_OKAY;
      end else if (rd_take) begin
         arready_q <= 1'h0;
         rvalid_q <= 1'h1;
         rdata_q <= rd_word;
         rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && rready) begin
         arready_q <= 1'h1;
         rvalid_q <= 1'h0;
      end
   end

   // ---------------------------------------------------------------
   // Control and status
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dog_fixed_enable_q <= RST_FIXED_EN;
         window_mode_off_q <= RST_WIN_OFF;
         prescale_ratio_sel_q <= RST_PRE_SEL;
         postscale_sel_q <= RST_POST_SEL;
         dog_soft_enable_q <= RST_SOFT_EN;
         dog_timeout_flag_q <= RST_FLAG;
         sleep_flag_q <= RST_FLAG;
         idle_flag_q <= RST_FLAG;
         pwr_q <= PWR_RUN;
      end else begin
         if (cfg_we) begin
            dog_fixed_enable_q <= wr_data_q[BIT_FIXED_EN];
            window_mode_off_q <= wr_data_q[BIT_WIN_OFF];
            prescale_ratio_sel_q <= wr_data_q[BIT_PRE_SEL];
            postscale_sel_q <= wr_data_q[LSB_POST_SEL +: POST_SEL_W];
         end
         if (ctl_we) begin
            dog_soft_enable_q <= wr_data_q[BIT_SOFT_EN];
         end
         dog_timeout_flag_q <= dog_timeout_flag_d;
         sleep_flag_q <= sleep_flag_d;
         idle_flag_q <= idle_flag_d;
         pwr_q <= pwr_d;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_en_q <= 1'h0;
         reset_req_q <= 1'h0;
         wake_q <= 1'h0;
      end else begin
         osc_en_q <= dog_en;
         reset_req_q <= dog_event && running;
         wake_q <= post_timeout && !running;
      end
   end
   assign awready = aw_free_q;
   assign wready = w_free_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign low_power_rc_osc_en = osc_en_q;
   assign dog_reset_req = reset_req_q;
   assign dog_wake = wake_q;
   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_osc_follows_en: assert property (dog_en |=> low_power_rc_osc_en)
      else $error("RC oscillator not enabled with the watchdog.");
   a_pre_ratio: assert property (pre_div.tick |->
         pre_div.cnt == (prescale_ratio_sel_q ? PRE_LAST_LONG : PRE_LAST_SHORT))
      else $error("Prescaler ticked at the wrong count.");
   a_base_period: assert property ((postscale_sel_q == 4'h0 && pre_div.tick) |->
         post_timeout)
      else $error("Base period not one prescaler period.");
   a_post_ratio: assert property (post_timeout |->
         post_div.cnt == POST_W'((16'h0001 << postscale_sel_q) - 16'h0001))
      else $error("Postscaler ratio does not match select.");
   a_clear_chain: assert property (clr_all |=>
         (osc_div.cnt == '0 && pre_div.cnt == '0 && post_div.cnt == '0))
      else $error("Counters not cleared.");
   a_switch_clear: assert property (clock_switch_done |=> post_div.cnt == '0)
      else $error("Clock switch did not clear the postscaler.");
   a_save_entry: assert property ((running && power_save_instr) |=>
         (pwr_q != PWR_RUN && osc_div.cnt == '0))
      else $error("Power-save entry mishandled.");
   a_sleep_counts: assert property ((!running && dog_en && !clr_all) |=>
         osc_div.cnt != $past(osc_div.cnt))
      else $error("Watchdog stopped in sleep or idle.");
   a_wake_no_reset: assert property ((post_timeout && !running) |=>
         (dog_wake && !dog_reset_req && pwr_q == PWR_RUN) ##1 !dog_wake)
      else $error("Sleep time-out did not wake cleanly.");
   a_flag_sticky: assert property ((dog_timeout_flag_q && !ctl_we) |=>
         dog_timeout_flag_q)
      else $error("Timeout flag cleared on its own.");
   a_fixed_runs: assert property (dog_fixed_enable_q |=> low_power_rc_osc_en)
      else $error("Fixed enable did not run the watchdog.");
   a_off_idle: assert property ((!dog_en) [*2] |-> post_div.cnt == '0)
      else $error("Disabled watchdog still counting.");
   a_run_reset: assert property ((dog_event && running) |=>
         (dog_reset_req && dog_timeout_flag_q))
      else $error("Run time-out did not request reset.");
endmodule : wtc_core

/* File: verification/wtc_core_bench.sv */
// Self-checking bench for the watchdog timer core: register bus and core event ports.
`timescale 1ns/1ns
module wtc_core_bench;
   import wtc_pkg::*;

   // ----------------------------------------------------------------
   // Signals and design instance
   // ----------------------------------------------------------------
   localparam int T_SHORT = RC_DIV * PRE_RATIO_SHORT;
   localparam int T_LONG = RC_DIV * PRE_RATIO_LONG;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [2:0] awprot = 3'h0, arprot = 3'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic dog_clear_instr = 1'h0, power_save_instr = 1'h0, power_save_idle = 1'h0;
   logic clock_switch_done = 1'h0, wake_other = 1'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic low_power_rc_osc_en, dog_reset_req, dog_wake;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int miscompares = 0;
   int check_count = 0;

   always #50 aclk = ~aclk;

   wtc_core i_wtc_core (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .dog_clear_instr, .power_save_instr, .power_save_idle,
      .clock_switch_done, .wake_other, .low_power_rc_osc_en, .dog_reset_req, .dog_wake);

   // ----------------------------------------------------------------
   // Report and compare tasks
   // ----------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out

   task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check_word

   task automatic check_cycles(input string what, input int exp, input int got);
      check_count++;
      if (got != exp) begin
         miscompares++;
         $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
      end
   endtask : check_cycles

   task automatic give_up(input string what);
      miscompares++;
      $display("unexpected hang waiting for %s", what);
      close_out();
   endtask : give_up

   // ----------------------------------------------------------------
   // Register bus tasks
   // ----------------------------------------------------------------
   task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d,
      input logic [1:0] exp_resp);
      int n;
      logic aw_ok;
      logic w_ok;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'h1;
      wdata <= d;
      wstrb <= 4'hF;
      wvalid <= 1'h1;
      bready <= 1'h1;
      aw_ok = 1'h0;
      w_ok = 1'h0;
      n = 0;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         n++;
         if (n > 50) give_up("write request");
         if (!aw_ok && awready === 1'h1) begin
            aw_ok = 1'h1;
            awvalid <= 1'h0;
         end
         if (!w_ok && wready === 1'h1) begin
            w_ok = 1'h1;
            wvalid <= 1'h0;
         end
      end
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (n > 50) give_up("write answer");
      end while (bvalid !== 1'h1);
      check_word("write response", {30'h0, exp_resp}, {30'h0, bresp});
      bready <= 1'h0;
   endtask : axi_write

   task automatic read_check(input string what, input logic [ADDR_W-1:0] a,
      input logic [31:0] exp, input logic [1:0] exp_resp);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (n > 50) give_up("read request");
      end while (arready !== 1'h1);
      arvalid <= 1'h0;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (n > 50) give_up("read answer");
      end while (rvalid !== 1'h1);
      check_word(what, exp, rdata);
      check_word("read response", {30'h0, exp_resp}, {30'h0, rresp});
      rready <= 1'h0;
   endtask : read_check

   // ----------------------------------------------------------------
   // Core event tasks
   // ----------------------------------------------------------------
   // Kinds: 0 clear, 1 power save, 2 clock switch done, 3 other wake source.
   task automatic pulse(input int kind, input logic idle);
      @(posedge aclk);
      power_save_idle <= idle;
      case (kind)
         0: dog_clear_instr <= 1'h1;
         1: power_save_instr <= 1'h1;
         2: clock_switch_done <= 1'h1;
         default: wake_other <= 1'h1;
      endcase
      @(posedge aclk);
      dog_clear_instr <= 1'h0;
      power_save_instr <= 1'h0;
      clock_switch_done <= 1'h0;
      wake_other <= 1'h0;
   endtask : pulse

   task automatic wait_timeout(input string what, input logic want_wake, input int exp);
      int n;
      n = 0;
      do begin
         @(posedge aclk);
         #1;
         n++;
         if (n > exp + 100) give_up(what);
      end while (dog_wake !== 1'h1 && dog_reset_req !== 1'h1);
      check_cycles(what, exp, n);
      check_word("wake pulse", {31'h0, want_wake}, {31'h0, dog_wake});
      check_word("reset request", {31'h0, ~want_wake}, {31'h0, dog_reset_req});
      @(posedge aclk);
      #1;
      check_word("pulse width", 32'h0, {30'h0, dog_wake, dog_reset_req});
   endtask : wait_timeout

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (3) @(posedge aclk);
      #1;
      check_word("rc enable", 32'h1, {31'h0, low_power_rc_osc_en});
      read_check("config", OFF_CONFIG, 32'h000000FF, RESP_OKAY);
      read_check("control", OFF_CONTROL, 32'h0, RESP_OKAY);
      axi_write(OFF_CONFIG, 32'h000000C0, RESP_OKAY);
      read_check("config", OFF_CONFIG, 32'h000000E0, RESP_OKAY);
      repeat (1000) @(posedge aclk);
      pulse(0, 1'h0);
      wait_timeout("run time-out", 1'h0, T_SHORT);
      read_check("control", OFF_CONTROL, 32'h00000010, RESP_OKAY);
      axi_write(OFF_CONTROL, 32'h00000010, RESP_OKAY);
      read_check("control", OFF_CONTROL, 32'h00000010, RESP_OKAY);
      axi_write(OFF_CONTROL, 32'h0, RESP_OKAY);
      read_check("control", OFF_CONTROL, 32'h0, RESP_OKAY);
      repeat (1000) @(posedge aclk);
      pulse(1, 1'h0);
      wait_timeout("sleep time-out", 1'h1, T_SHORT);
      read_check("control", OFF_CONTROL, 32'h00000018, RESP_OKAY);
      axi_write(OFF_CONTROL, 32'h0, RESP_OKAY);
      axi_write(OFF_CONFIG, 32'h000000C1, RESP_OKAY);
      pulse(1, 1'h1);
      repeat (1000) @(posedge aclk);
      pulse(3, 1'h0);
      wait_timeout("postscale time-out", 1'h0, 2 * T_SHORT);
      read_check("control", OFF_CONTROL, 32'h00000014, RESP_OKAY);
      axi_write(OFF_CONFIG, 32'h000000D0, RESP_OKAY);
      repeat (1000) @(posedge aclk);
      pulse(2, 1'h0);
      wait_timeout("long time-out", 1'h0, T_LONG);
      axi_write(OFF_CONTROL, 32'h0, RESP_OKAY);
      axi_write(OFF_CONFIG, 32'h00000081, RESP_OKAY);
      pulse(0, 1'h0);
      #1;
      check_word("window reset", 32'h1, {31'h0, dog_reset_req});
      read_check("control", OFF_CONTROL, 32'h00000010, RESP_OKAY);
      axi_write(OFF_COUNT, 32'h00007FFF, RESP_OKAY);
      read_check("count", OFF_COUNT, 32'h0, RESP_OKAY);
      axi_write(8'h0C, 32'hFFFFFFFF, RESP_SLVERR);
      read_check("unmapped", 8'h0C, 32'h0, RESP_SLVERR);
      axi_write(OFF_CONFIG, 32'h00000040, RESP_OKAY);
      axi_write(OFF_CONTROL, 32'h0, RESP_OKAY);
      repeat (3) @(posedge aclk);
      #1;
      check_word("rc enable off", 32'h0, {31'h0, low_power_rc_osc_en});
      axi_write(OFF_CONTROL, 32'h00000020, RESP_OKAY);
      repeat (3) @(posedge aclk);
      #1;
      check_word("rc enable soft", 32'h1, {31'h0, low_power_rc_osc_en});
      read_check("control", OFF_CONTROL, 32'h00000020, RESP_OKAY);
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      read_check("control", OFF_CONTROL, 32'h0, RESP_OKAY);
      read_check("config", OFF_CONFIG, 32'h000000FF, RESP_OKAY);
      close_out();
   end
endmodule : wtc_core_bench
